// file: logic/dsg_cfg.svh
`ifndef DSG_CFG_SVH
`define DSG_CFG_SVH

`define DSG_ADDR_W           12
`define DSG_OFS_RUN_CLK_CFG  12'h060
`define DSG_OFS_RUN_GATE     12'h104
`define DSG_OFS_SLEEP_GATE   12'h114
`define DSG_OFS_DEEP_GATE    12'h124
`define DSG_OFS_INT_STAT     12'h200
`define DSG_OFS_INT_EN       12'h204
`define DSG_OFS_INT_CLR      12'h208

`define DSG_GATE_MASK        32'h0307_0011
`define DSG_GATE_RESET       32'h0000_0000
`define DSG_CFG_MASK         32'h0000_0001
`define DSG_AUTO_GATE_BIT    0

`define DSG_NUM_UNITS        7
`define DSG_POS_W            5
// Unit 6..0: comparator_b, comparator_a, timer_c, timer_b, timer_a, sync_serial, async_serial
`define DSG_UNIT_POS         {5'h19, 5'h18, 5'h12, 5'h11, 5'h10, 5'h04, 5'h00}

`endif

// file: logic/dsg_pkg.sv
`include "dsg_cfg.svh"

package dsg_pkg;

  typedef enum logic [2:0] {
    DSG_PWR_RUN   = 3'h1,
    DSG_PWR_SLEEP = 3'h2,
    DSG_PWR_DEEP  = 3'h4
  } dsg_pwr_t;

  typedef enum logic [1:0] {
    DSG_BUS_IDLE = 2'h1,
    DSG_BUS_DONE = 2'h2
  } dsg_bus_t;

  typedef struct packed {
    dsg_bus_t    bus;
    logic [31:0] run;
    logic [31:0] sleep;
    logic [31:0] deep;
    logic        auto_gate;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dsg_top_st_t;

  typedef struct packed {
    logic [31:0] stat;
    logic [31:0] en;
    logic        irq;
  } dsg_irq_st_t;

  typedef struct packed {
    logic clk_en;
    logic fault;
  } dsg_unit_st_t;

endpackage

// file: logic/dsg_unit_gate.sv
`timescale 1ns/100ps

module dsg_unit_gate (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run_bit,
  input  wire logic              sleep_bit,
  input  wire logic              deep_bit,
  input  wire logic              auto_gate_select,
  input  wire dsg_pkg::dsg_pwr_t pwr_state,
  input  wire logic              unit_access,
  output logic                   clk_en_r,
  output logic                   fault_r
);
  import dsg_pkg::*;

  dsg_unit_st_t st_r;
  dsg_unit_st_t st_nxt;
  logic         sel;

  always_comb begin
    sel = run_bit;
    if (auto_gate_select) begin
      case (pwr_state)
        DSG_PWR_RUN:   sel = run_bit;
        DSG_PWR_SLEEP: sel = sleep_bit;
        DSG_PWR_DEEP:  sel = deep_bit;
        default:       sel = run_bit;
      endcase
    end
    st_nxt        = st_r;
    st_nxt.clk_en = sel;
    // Judged on the enable the unit sees now, not the one being loaded
    st_nxt.fault  = unit_access & ~st_r.clk_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_en_r = st_r.clk_en;
  assign fault_r  = st_r.fault;
endmodule

// file: logic/dsg_irq.sv
`timescale 1ns/100ps
`include "dsg_cfg.svh"

module dsg_irq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] events,
  input  wire logic        en_wr,
  input  wire logic        clr_wr,
  input  wire logic [31:0] wdata,
  output logic [31:0]      stat_r,
  output logic [31:0]      en_r,
  output logic             irq_r
);
  import dsg_pkg::*;

  dsg_irq_st_t st_r;
  dsg_irq_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (en_wr) begin
      st_nxt.en = wdata & `DSG_GATE_MASK;
    end
    if (clr_wr) begin
      st_nxt.stat = st_r.stat & ~wdata;
    end
    // Set after clear so a same-cycle event is kept
    st_nxt.stat = (st_nxt.stat | events) & `DSG_GATE_MASK;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat_r = st_r.stat;
  assign en_r   = st_r.en;
  assign irq_r  = st_r.irq;
endmodule

// file: logic/dsg_top.sv
// Notes on behaviour
// - Set enable bit clocks its unit
// - Cleared enable bit stops unit clock
// - Access to gated unit answers bus fault
// - All enable bits reset to zero
// - Run, sleep, deep registers chosen by state
// - Sleep, deep apply only with auto select
// - Bits 18,17,16 gate timers c,b,a
// - Bit 4 sync serial, bit 0 async
// - Reserved bits read zero, ignore writes
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "dsg_cfg.svh"

module dsg_top #(
  parameter int unsigned NUM_UNITS = `DSG_NUM_UNITS
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`DSG_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire dsg_pkg::dsg_pwr_t      pwr_state,
  input  wire logic [NUM_UNITS-1:0]   unit_access,
  output logic [NUM_UNITS-1:0]        unit_clk_en,
  output logic [NUM_UNITS-1:0]        unit_fault,
  output logic                        irq
);
  import dsg_pkg::*;

  localparam logic [`DSG_NUM_UNITS*`DSG_POS_W-1:0] UNIT_POS = `DSG_UNIT_POS;

  dsg_top_st_t st_r;
  dsg_top_st_t st_nxt;

  logic [31:0] rd_data;
  logic        hit;
  logic        wr_go;
  logic        en_wr;
  logic        clr_wr;
  logic [31:0] fault_vec;
  logic [31:0] int_stat;
  logic [31:0] int_en;

  // Address decode and read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    case (paddr)
      `DSG_OFS_RUN_CLK_CFG: begin
        rd_data[`DSG_AUTO_GATE_BIT] = st_r.auto_gate;
      end
      `DSG_OFS_RUN_GATE: begin
        rd_data = st_r.run & `DSG_GATE_MASK;
      end
      `DSG_OFS_SLEEP_GATE: begin
        rd_data = st_r.sleep & `DSG_GATE_MASK;
      end
      `DSG_OFS_DEEP_GATE: begin
        rd_data = st_r.deep & `DSG_GATE_MASK;
      end
      `DSG_OFS_INT_STAT: begin
        rd_data = int_stat;
      end
      `DSG_OFS_INT_EN: begin
        rd_data = int_en;
      end
      `DSG_OFS_INT_CLR: begin
        rd_data = 32'h0000_0000;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // A write lands only on the edge that samples pready high
  assign wr_go  = (st_r.bus == DSG_BUS_DONE) && psel && penable && pwrite && !st_r.pslverr;
  assign en_wr  = wr_go && (paddr == `DSG_OFS_INT_EN);
  assign clr_wr = wr_go && (paddr == `DSG_OFS_INT_CLR);

  // One wait state keeps pready a flop output
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    case (st_r.bus)
      DSG_BUS_IDLE: begin
        if (psel && penable) begin
          st_nxt.bus     = DSG_BUS_DONE;
          st_nxt.pready  = 1'b1;
          st_nxt.pslverr = ~hit;
          st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_data;
        end
      end
      DSG_BUS_DONE: begin
        st_nxt.bus = DSG_BUS_IDLE;
        if (wr_go) begin
          case (paddr)
            `DSG_OFS_RUN_CLK_CFG: begin
              st_nxt.auto_gate = pwdata[`DSG_AUTO_GATE_BIT];
            end
            `DSG_OFS_RUN_GATE: begin
              st_nxt.run = pwdata & `DSG_GATE_MASK;
            end
            `DSG_OFS_SLEEP_GATE: begin
              st_nxt.sleep = pwdata & `DSG_GATE_MASK;
            end
            `DSG_OFS_DEEP_GATE: begin
              st_nxt.deep = pwdata & `DSG_GATE_MASK;
            end
            default: begin
              st_nxt.bus = DSG_BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        st_nxt.bus = DSG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.bus       <= DSG_BUS_IDLE;
      st_r.run       <= `DSG_GATE_RESET;
      st_r.sleep     <= `DSG_GATE_RESET;
      st_r.deep      <= `DSG_GATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready  = st_r.pready;
  assign prdata  = st_r.prdata;
  assign pslverr = st_r.pslverr;

  // Per-unit clock enable and fault; the enable drives the unit's clock gate cell
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g = g + 1) begin : g_unit
      localparam int unsigned P = int'(UNIT_POS[g*`DSG_POS_W +: `DSG_POS_W]);
      dsg_unit_gate u_gate (
        .pclk             (pclk),
        .presetn          (presetn),
        .run_bit          (st_r.run[P]),
        .sleep_bit        (st_r.sleep[P]),
        .deep_bit         (st_r.deep[P]),
        .auto_gate_select (st_r.auto_gate),
        .pwr_state        (pwr_state),
        .unit_access      (unit_access[g]),
        .clk_en_r         (unit_clk_en[g]),
        .fault_r          (unit_fault[g])
      );
    end
  endgenerate

  // Faults logged at the unit's own bit position
  always_comb begin
    fault_vec = 32'h0000_0000;
    for (int i = 0; i < NUM_UNITS; i++) begin
      fault_vec[UNIT_POS[i*`DSG_POS_W +: `DSG_POS_W]] = unit_fault[i];
    end
  end

  dsg_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (fault_vec),
    .en_wr   (en_wr),
    .clr_wr  (clr_wr),
    .wdata   (pwdata),
    .stat_r  (int_stat),
    .en_r    (int_en),
    .irq_r   (irq)
  );

  // Checks
  sequence s_deep_wr;
    wr_go && (paddr == `DSG_OFS_DEEP_GATE);
  endsequence

  sequence s_run_wr;
    wr_go && (paddr == `DSG_OFS_RUN_GATE);
  endsequence

  sequence s_gate_rd;
    (st_r.bus == DSG_BUS_IDLE) && psel && penable && !pwrite &&
    ((paddr == `DSG_OFS_RUN_GATE) || (paddr == `DSG_OFS_SLEEP_GATE) ||
     (paddr == `DSG_OFS_DEEP_GATE));
  endsequence

  property p_rst_zero;
    @(posedge pclk)
    $rose(presetn) |-> (st_r.run == 32'h0) && (st_r.sleep == 32'h0) && (st_r.deep == 32'h0);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("gate bits not zero after reset");

  property p_rst_clk_off;
    @(posedge pclk)
    $rose(presetn) |-> (unit_clk_en == '0);
  endproperty
  a_rst_clk_off: assert property (p_rst_clk_off) else $error("unit clocked after reset");

  property p_deep_store;
    @(posedge pclk) disable iff (!presetn)
    s_deep_wr |=> (st_r.deep == ($past(pwdata) & `DSG_GATE_MASK));
  endproperty
  a_deep_store: assert property (p_deep_store) else $error("deep gate write lost");

  property p_rsvd_read;
    @(posedge pclk) disable iff (!presetn)
    s_gate_rd |=> pready && ((prdata & ~`DSG_GATE_MASK) == 32'h0);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero");

  property p_run_path;
    @(posedge pclk) disable iff (!presetn)
    !st_r.auto_gate |=> (unit_clk_en[0] == $past(st_r.run[0]));
  endproperty
  a_run_path: assert property (p_run_path) else $error("run gating ignored");

  property p_deep_path;
    @(posedge pclk) disable iff (!presetn)
    st_r.auto_gate && (pwr_state == DSG_PWR_DEEP) |=> (unit_clk_en[4] == $past(st_r.deep[18]));
  endproperty
  a_deep_path: assert property (p_deep_path) else $error("deep gating not applied");

  property p_sleep_path;
    @(posedge pclk) disable iff (!presetn)
    st_r.auto_gate && (pwr_state == DSG_PWR_SLEEP) |=> (unit_clk_en[6] == $past(st_r.sleep[25]));
  endproperty
  a_sleep_path: assert property (p_sleep_path) else $error("sleep gating not applied");

  property p_en_on;
    @(posedge pclk) disable iff (!presetn)
    s_run_wr ##1 (!st_r.auto_gate && st_r.run[4]) |=> unit_clk_en[1];
  endproperty
  a_en_on: assert property (p_en_on) else $error("enabled unit not clocked");

  property p_en_off;
    @(posedge pclk) disable iff (!presetn)
    (!st_r.auto_gate && !st_r.run[16]) [*2] |-> !unit_clk_en[2];
  endproperty
  a_en_off: assert property (p_en_off) else $error("gated unit still clocked");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
    unit_access[0] && !unit_clk_en[0] |=> unit_fault[0] ##1 int_stat[0];
  endproperty
  a_fault: assert property (p_fault) else $error("gated access not faulted");

  property p_no_fault;
    @(posedge pclk) disable iff (!presetn)
    unit_access[3] && unit_clk_en[3] |=> !unit_fault[3];
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault on clocked unit");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    (st_r.bus == DSG_BUS_IDLE) && psel && penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer not one wait state");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    |(int_stat & int_en) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// file: dv/dsg_top_tb.sv
`timescale 1ns/100ps
`include "dsg_cfg.svh"

module dsg_top_tb;
  import dsg_pkg::*;
  localparam int POS [7] = '{0, 4, 16, 17, 18, 24, 25};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  dsg_pwr_t    pwr_state;
  logic [6:0]  unit_access;
  logic [6:0]  unit_clk_en;
  logic [6:0]  unit_fault;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          mismatches;
  int          checks;
  logic [11:0] ofs [6] = '{`DSG_OFS_RUN_GATE, `DSG_OFS_SLEEP_GATE, `DSG_OFS_DEEP_GATE,
                           `DSG_OFS_RUN_CLK_CFG, `DSG_OFS_INT_STAT, `DSG_OFS_INT_EN};
  // Last entry is an illegal code, which must fall back to the run register
  dsg_pwr_t    st [4] = '{DSG_PWR_RUN, DSG_PWR_SLEEP, DSG_PWR_DEEP, dsg_pwr_t'(3'h0)};
  logic [31:0] rg [3];
  logic [6:0]  ce;
  int unsigned seed;

  dsg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pwr_state(pwr_state), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
    .unit_fault(unit_fault), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Sampling right after the edge sees pre-edge register values
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) mismatches++;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task chk_unit(input logic [6:0] got, input logic [6:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [6:0] units(input logic [31:0] w);
    logic [6:0] u;
    for (int i = 0; i < 7; i++) u[i] = w[POS[i]];
    return u;
  endfunction

  // Invalid or run state falls back to the run register
  function automatic logic [31:0] pick(input logic a, input dsg_pwr_t s);
    if (a && s == DSG_PWR_SLEEP) return rg[1] & `DSG_GATE_MASK;
    if (a && s == DSG_PWR_DEEP) return rg[2] & `DSG_GATE_MASK;
    return rg[0] & `DSG_GATE_MASK;
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    test_done;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pwr_state = DSG_PWR_RUN; unit_access = 7'h00; mismatches = 0; checks = 0;
    seed = $urandom(98);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[k]) begin
      apb(1'b0, ofs[k], 32'h0);
      chk_word(rd, 32'h0, "reset value");
    end
    chk_unit(unit_clk_en, 7'h00, "reset gating");
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < 4; n++) begin
        rg[k] = (n == 0) ? 32'hffff_ffff : $urandom;
        apb(1'b1, ofs[k], rg[k]);
        apb(1'b0, ofs[k], 32'h0);
        chk_word(rd, rg[k] & `DSG_GATE_MASK, "gate readback");
      end
    end
    apb(1'b1, 12'h3fc, 32'hffff_ffff);
    chk_unit({6'h00, err}, 7'h01, "unmapped write error");
    apb(1'b0, 12'h3fc, 32'h0);
    chk_unit({6'h00, err}, 7'h01, "unmapped read error");
    chk_word(rd, 32'h0, "unmapped read data");
    $display("test registers done");
    for (int a = 0; a < 2; a++) begin
      foreach (st[s]) begin
        pwr_state <= st[s];
        for (int k = 0; k < 3; k++) begin
          rg[k] = $urandom;
          apb(1'b1, ofs[k], rg[k]);
        end
        apb(1'b1, `DSG_OFS_RUN_CLK_CFG, a);
        repeat (2) @(posedge pclk);
        chk_unit(unit_clk_en, units(pick(a[0], st[s])), "clock enable select");
      end
    end
    $display("test selection done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[k]) begin
      apb(1'b0, ofs[k], 32'h0);
      chk_word(rd, 32'h0, "value after mid-run reset");
    end
    chk_unit(unit_clk_en, 7'h00, "gating after mid-run reset");
    apb(1'b1, `DSG_OFS_DEEP_GATE, 32'h0100_0001);
    apb(1'b0, `DSG_OFS_DEEP_GATE, 32'h0);
    apb(1'b1, `DSG_OFS_DEEP_GATE, rd | 32'h0004_0000);
    apb(1'b0, `DSG_OFS_DEEP_GATE, 32'h0);
    chk_word(rd, 32'h0104_0001, "read-modify-write");
    $display("test mid reset done");
    apb(1'b1, `DSG_OFS_RUN_CLK_CFG, 32'h0);
    rg[0] = $urandom;
    apb(1'b1, `DSG_OFS_RUN_GATE, rg[0]);
    ce = units(rg[0] & `DSG_GATE_MASK);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, `DSG_OFS_INT_EN, i[0] ? `DSG_GATE_MASK : 32'h0);
      unit_access <= 7'h01 << i;
      @(posedge pclk);
      unit_access <= 7'h00;
      @(posedge pclk);
      chk_unit(unit_fault, ce[i] ? 7'h00 : 7'h01 << i, "fault pulse");
      apb(1'b1, `DSG_OFS_INT_STAT, 32'hffff_ffff);
      apb(1'b0, `DSG_OFS_INT_STAT, 32'h0);
      chk_word(rd, ce[i] ? 32'h0 : 32'h1 << POS[i], "fault status");
      chk_unit({6'h00, irq}, {6'h00, ~ce[i] & i[0]}, "interrupt level");
      apb(1'b1, `DSG_OFS_INT_CLR, 32'h1 << POS[i]);
      apb(1'b0, `DSG_OFS_INT_STAT, 32'h0);
      chk_word(rd, 32'h0, "status cleared");
      chk_unit({6'h00, irq}, 7'h00, "interrupt cleared");
    end
    $display("test fault done");
    test_done;
  end
endmodule
